/* rtl/fer_params.svh */
`ifndef FER_PARAMS_SVH
`define FER_PARAMS_SVH

// register indexes; byte address on the bus is index * 4
`define FER_IDX_C0        16'h40c0
`define FER_IDX_C1        16'h40c1
`define FER_IDX_C2        16'h40c2
`define FER_IDX_C3        16'h40c3
`define FER_IDX_C4        16'h40c4
`define FER_IDX_C5        16'h40c5
`define FER_IDX_C6        16'h40c6
`define FER_IDX_C7        16'h40c7
`define FER_IDX_C8        16'h40c8
`define FER_IDX_C9        16'h40c9
`define FER_IDX_CA        16'h40ca
`define FER_IDX_CB        16'h40cb
`define FER_IDX_CC        16'h40cc
`define FER_IDX_CD        16'h40cd

// field positions inside a 16-bit pair
`define FER_HI_MSB        15
`define FER_HI_LSB        8
`define FER_LO_MSB        7
`define FER_LO_LSB        0

// reset values
`define FER_COEF_RST      8'hff
`define FER_WORD_RST      16'h0000

// saturation limits of the compensated voltages
`define FER_SAT_MAX       16'h7fff
`define FER_SAT_MIN       16'h8000

`endif

/* rtl/fer_pkg.sv */
package fer_pkg;

	// quantities measured or computed by the engine
	typedef struct packed {
		logic signed [15:0] beta_current;
		logic signed [15:0] beta_voltage;
		logic signed [15:0] alpha_voltage;
		logic signed [15:0] phase_a_current;
		logic signed [15:0] phase_b_current;
		logic signed [15:0] phase_c_current;
	} fer_obs_s;

	// tuning parameters handed to the engine
	typedef struct packed {
		logic        [7:0]  q_current_filter_coef;
		logic        [7:0]  d_current_filter_coef;
		logic signed [15:0] motor_flux_param;
		logic signed [15:0] q_inductance_param;
		logic signed [15:0] d_inductance_param;
	} fer_tune_s;

	// whole state of the slice
	typedef struct packed {
		logic        [1:0]  unused_pad;
		fer_tune_s          tune;
		logic signed [15:0] d_voltage_comp;
		logic signed [15:0] q_voltage_comp;
		logic signed [15:0] output_angle;
		fer_obs_s           obs;
		logic signed [15:0] d_voltage_sum;
		logic signed [15:0] q_voltage_sum;
		logic               pready;
		logic               pslverr;
		logic        [31:0] prdata;
	} fer_state_s;

endpackage

/* rtl/fer_regs.sv */
// Behaviour
// - reading indexes 40c0/40c1 returns the signed beta-axis current, read only, reset zero.
// - a write to index 40c0 sets the 8-bit q-axis current filter coefficient, reset ff.
// - a write to index 40c1 sets the 8-bit d-axis current filter coefficient, reset ff.
// - reading indexes 40c2/40c3 returns the signed beta-axis output voltage, reset zero.
// - writing 40c2/40c3 sets the d compensation, added to the d PI output downstream.
// - writing 40c4/40c5 sets the q compensation, added to the q PI output downstream.
// - indexes 40c4/40c5 also carry the signed alpha-axis output voltage, reset zero.
// - writing 40c6/40c7 sets the motor flux parameter, write only, reset zero.
// - reading 40c6/40c7 returns the sampled phase C current, reset zero.
// - writing 40c8/40c9 sets the q-axis inductance parameter, reset zero.
// - reading 40c8/40c9 returns the sampled phase B current, reset zero.
// - writing 40ca/40cb sets the d-axis inductance parameter, reset zero.
// - reading 40ca/40cb returns the sampled phase A current, reset zero.
// - the output angle at 40cc/40cd is read/write, reset zero, full scale is +-180 degrees.
// - the output angle is the estimator angle plus the angle compensation value.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "fer_params.svh"

module fer_regs (
	// clock and reset
	input  wire  logic                clk,
	input  wire  logic                resetn,
	// apb slave
	input  wire  logic                psel,
	input  wire  logic                penable,
	input  wire  logic                pwrite,
	input  wire  logic [17:0]         paddr,
	input  wire  logic [31:0]         pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// engine quantities in
	input  wire  fer_pkg::fer_obs_s   obs_in,
	input  wire  logic signed [15:0]  d_pi_output,
	input  wire  logic signed [15:0]  q_pi_output,
	input  wire  logic signed [15:0]  est_angle,
	input  wire  logic                est_angle_valid,
	input  wire  logic signed [15:0]  angle_compensation,
	// engine parameters out
	output fer_pkg::fer_tune_s        tune_out,
	output logic signed [15:0]        d_voltage_out,
	output logic signed [15:0]        q_voltage_out,
	output logic signed [15:0]        output_angle,
	output logic signed [15:0]        alpha_voltage_out
);
	import fer_pkg::*;

	logic       rst_meta_q;
	logic       rst_sync_q;
	fer_state_s st_q;
	fer_state_s st_d;

	// saturating add keeps a wrapped sum from flipping the voltage sign
	function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15]) begin
			sat_add = s[16] ? `FER_SAT_MIN : `FER_SAT_MAX;
		end else begin
			sat_add = s[15:0];
		end
	endfunction

	// reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	logic        setup;
	logic        access;
	logic [15:0] idx;
	logic        mapped;
	logic [7:0]  wbyte;

	assign setup  = psel & ~penable;
	assign access = psel & penable & st_q.pready;
	assign idx    = paddr[17:2];
	assign wbyte  = pwdata[7:0];
	// only word-aligned accesses inside the slice are answered without error
	assign mapped = (paddr[1:0] == 2'b00) && (idx >= `FER_IDX_C0) && (idx <= `FER_IDX_CD);

	// next state
	always_comb begin
		st_d = st_q;
		st_d.unused_pad = 2'b00;

		// engine observations are sampled every cycle
		st_d.obs = obs_in;

		// compensated voltages for the following stage
		st_d.d_voltage_sum = sat_add(d_pi_output, st_q.d_voltage_comp);
		st_d.q_voltage_sum = sat_add(q_pi_output, st_q.q_voltage_comp);

		// angle is modular, so the plain wrapping sum is what we want
		if (est_angle_valid) begin
			st_d.output_angle = est_angle + angle_compensation;
		end

		// one-cycle answer: pready raised for the first access cycle
		st_d.pready  = setup;
		st_d.pslverr = 1'b0;
		st_d.prdata  = 32'h0000_0000;
		if (setup) begin
			st_d.pslverr = ~mapped;
			if (!pwrite && mapped) begin
				// reads see the measured quantity at shared indexes
				case (idx)
					`FER_IDX_C0: st_d.prdata[7:0] = st_q.obs.beta_current[15:8];
					`FER_IDX_C1: st_d.prdata[7:0] = st_q.obs.beta_current[7:0];
					`FER_IDX_C2: st_d.prdata[7:0] = st_q.obs.beta_voltage[15:8];
					`FER_IDX_C3: st_d.prdata[7:0] = st_q.obs.beta_voltage[7:0];
					`FER_IDX_C4: st_d.prdata[7:0] = st_q.obs.alpha_voltage[15:8];
					`FER_IDX_C5: st_d.prdata[7:0] = st_q.obs.alpha_voltage[7:0];
					`FER_IDX_C6: st_d.prdata[7:0] = st_q.obs.phase_c_current[15:8];
					`FER_IDX_C7: st_d.prdata[7:0] = st_q.obs.phase_c_current[7:0];
					`FER_IDX_C8: st_d.prdata[7:0] = st_q.obs.phase_b_current[15:8];
					`FER_IDX_C9: st_d.prdata[7:0] = st_q.obs.phase_b_current[7:0];
					`FER_IDX_CA: st_d.prdata[7:0] = st_q.obs.phase_a_current[15:8];
					`FER_IDX_CB: st_d.prdata[7:0] = st_q.obs.phase_a_current[7:0];
					`FER_IDX_CC: st_d.prdata[7:0] = st_q.output_angle[15:8];
					`FER_IDX_CD: st_d.prdata[7:0] = st_q.output_angle[7:0];
					default:     st_d.prdata[7:0] = 8'h00;
				endcase
			end
		end

		// writes land only in the parameter; a software angle write beats the estimator
		if (access && pwrite && !st_q.pslverr) begin
			case (idx)
				`FER_IDX_C0: st_d.tune.q_current_filter_coef = wbyte;
				`FER_IDX_C1: st_d.tune.d_current_filter_coef = wbyte;
				`FER_IDX_C2: st_d.d_voltage_comp[`FER_HI_MSB:`FER_HI_LSB] = wbyte;
				`FER_IDX_C3: st_d.d_voltage_comp[`FER_LO_MSB:`FER_LO_LSB] = wbyte;
				`FER_IDX_C4: st_d.q_voltage_comp[`FER_HI_MSB:`FER_HI_LSB] = wbyte;
				`FER_IDX_C5: st_d.q_voltage_comp[`FER_LO_MSB:`FER_LO_LSB] = wbyte;
				`FER_IDX_C6: st_d.tune.motor_flux_param[`FER_HI_MSB:`FER_HI_LSB] = wbyte;
				`FER_IDX_C7: st_d.tune.motor_flux_param[`FER_LO_MSB:`FER_LO_LSB] = wbyte;
				`FER_IDX_C8: st_d.tune.q_inductance_param[`FER_HI_MSB:`FER_HI_LSB] = wbyte;
				`FER_IDX_C9: st_d.tune.q_inductance_param[`FER_LO_MSB:`FER_LO_LSB] = wbyte;
				`FER_IDX_CA: st_d.tune.d_inductance_param[`FER_HI_MSB:`FER_HI_LSB] = wbyte;
				`FER_IDX_CB: st_d.tune.d_inductance_param[`FER_LO_MSB:`FER_LO_LSB] = wbyte;
				`FER_IDX_CC: st_d.output_angle[`FER_HI_MSB:`FER_HI_LSB] = wbyte;
				`FER_IDX_CD: st_d.output_angle[`FER_LO_MSB:`FER_LO_LSB] = wbyte;
				default: ;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			st_q                            <= '0;
			st_q.tune.q_current_filter_coef <= `FER_COEF_RST;
			st_q.tune.d_current_filter_coef <= `FER_COEF_RST;
			st_q.output_angle               <= `FER_WORD_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state flops
	assign pready            = st_q.pready;
	assign prdata            = st_q.prdata;
	assign pslverr           = st_q.pslverr;
	assign tune_out          = st_q.tune;
	assign d_voltage_out     = st_q.d_voltage_sum;
	assign q_voltage_out     = st_q.q_voltage_sum;
	assign output_angle      = st_q.output_angle;
	assign alpha_voltage_out = st_q.obs.alpha_voltage;

endmodule

/* sim/fer_regs_props.sv */
`timescale 1ns/1ps
module fer_regs_props (
	// apb side, grouped to keep the checker short
	input wire logic                clk, resetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [17:0]         paddr,
	input wire logic [31:0]         prdata,
	// engine side
	input wire fer_pkg::fer_obs_s   obs_in,
	input wire fer_pkg::fer_tune_s  tune_out,
	input wire logic signed [15:0]  est_angle, angle_compensation, output_angle,
	input wire logic signed [15:0]  alpha_voltage_out,
	input wire logic                est_angle_valid
);
	logic [1:0] up_q;
	logic       live;
	logic       acc;
	// outputs only track inputs once the synced reset has let go
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	end
	assign live = (up_q == 2'h3);
	assign acc = psel && penable && pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_ready; live && psel && !penable |=> pready && penable; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_only; pready |-> psel && penable && $past(psel) && !$past(penable); endproperty
	a_only: assert property (p_only) else $error("ready outside access");
	property p_err; pready && (paddr < 18'h10300 || paddr > 18'h10334 || paddr[1:0] != 2'h0)
		|-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_beta; live && pready && !pwrite && paddr == 18'h10300
		|-> prdata[7:0] == $past(obs_in.beta_current[15:8], 2); endproperty
	a_beta: assert property (p_beta) else $error("beta current high byte wrong");
	property p_pha; live && pready && !pwrite && paddr == 18'h1032c
		|-> prdata[7:0] == $past(obs_in.phase_a_current[7:0], 2); endproperty
	a_pha: assert property (p_pha) else $error("phase a low byte wrong");
	property p_alpha; live |-> alpha_voltage_out == $past(obs_in.alpha_voltage); endproperty
	a_alpha: assert property (p_alpha) else $error("alpha voltage not tracked");
	property p_angle; live && est_angle_valid && !acc
		|=> output_angle == 16'($past(est_angle) + $past(angle_compensation)); endproperty
	a_angle: assert property (p_angle) else $error("angle sum wrong");
	property p_hold; live && !est_angle_valid && !acc |=> $stable(output_angle); endproperty
	a_hold: assert property (p_hold) else $error("angle moved by itself");
	property p_coef; live && !$stable(tune_out.q_current_filter_coef)
		|-> $past(acc) && $past(paddr) == 18'h10300; endproperty
	a_coef: assert property (p_coef) else $error("coef changed without write");
	c_read: cover property (pready && !pwrite);
	c_err: cover property (pready && pslverr);
	c_angle: cover property (est_angle_valid);
endmodule
bind fer_regs fer_regs_props u_props (.*);

/* sim/foc_engine_register_slice_tb_top.sv */
`timescale 1ns/1ps
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module foc_engine_register_slice_tb_top;
	import fer_pkg::*;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, est_angle_valid, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic signed [15:0] d_pi_output, q_pi_output, est_angle, angle_compensation, th;
	logic signed [15:0] d_voltage_out, q_voltage_out, output_angle, alpha_voltage_out;
	fer_obs_s obs_in;
	fer_tune_s tune_out;
	logic [7:0] b[12];
	int mismatches, comparisons, n;
	fer_regs dut_u (.*);
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one transfer; the wait for ready is bounded so a dead slave ends the run
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		// look at ready mid-cycle, where the registered answer has settled
		n = 0;
		do begin @(negedge clk); n++; end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin mismatches++; tally_and_finish(); end
		rd = prdata;
		err = pslverr;
		// the request stands through the edge at which ready is high
		@(posedge clk);
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [15:0] sat(int s);
		return s > 32767 ? 16'h7fff : s < -32768 ? 16'h8000 : 16'(s);
	endfunction
	// fresh engine quantities, then every byte read back, high byte first
	task automatic sweep;
		logic [15:0] v[7];
		obs_in <= {$urandom, $urandom, $urandom};
		repeat (2) @(posedge clk);
		v = '{obs_in.beta_current, obs_in.beta_voltage, obs_in.alpha_voltage,
			obs_in.phase_c_current, obs_in.phase_b_current, obs_in.phase_a_current, th};
		for (int i = 0; i < 14; i++) begin
			apb(1'b0, 18'h10300 + 18'(4 * i), 32'h0);
			`CK(rd, {24'h0, i[0] ? v[i / 2][7:0] : v[i / 2][15:8]})
		end
		`CK(alpha_voltage_out, obs_in.alpha_voltage)
	endtask
	initial begin
		{resetn, psel, penable, pwrite, est_angle_valid} = 5'h0;
		{paddr, pwdata, obs_in, th} = '0;
		{d_pi_output, q_pi_output, est_angle, angle_compensation} = '0;
		void'($urandom(32'h3a85));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		`CK(tune_out, {16'hffff, 48'h0})
		`CK({output_angle, d_voltage_out, q_voltage_out}, 48'h0)
		sweep();
		$display("test reset and reads done");
		// every writable byte except the angle pair, then shared reads must still show the quantities
		for (int i = 0; i < 12; i++) begin
			b[i] = 8'($urandom);
			apb(1'b1, 18'h10300 + 18'(4 * i), {24'h0, b[i]});
		end
		d_pi_output <= 16'sh7ff0;
		q_pi_output <= 16'($urandom);
		repeat (2) @(posedge clk);
		`CK(tune_out, {b[0], b[1], b[6], b[7], b[8], b[9], b[10], b[11]})
		`CK(d_voltage_out, sat(32'sh7ff0 + int'($signed({b[2], b[3]}))))
		`CK(q_voltage_out, sat(int'(q_pi_output) + int'($signed({b[4], b[5]}))))
		sweep();
		$display("test writes done");
		// refused places leave the parameters alone
		apb(1'b1, 18'h10338, 32'h5a);
		apb(1'b1, 18'h102fc, 32'h5a);
		apb(1'b0, 18'h10302, 32'h0);
		`CK({err, rd}, 33'h100000000)
		`CK(tune_out, {b[0], b[1], b[6], b[7], b[8], b[9], b[10], b[11]})
		$display("test refusals done");
		// 45 degrees by software, then estimator plus compensation
		apb(1'b1, 18'h10330, 32'h20);
		apb(1'b1, 18'h10334, 32'h0);
		th = 16'h2000;
		`CK(output_angle, th)
		est_angle <= 16'($urandom);
		angle_compensation <= 16'($urandom);
		est_angle_valid <= 1'b1;
		@(posedge clk) est_angle_valid <= 1'b0;
		@(posedge clk);
		th = 16'(est_angle + angle_compensation);
		`CK(output_angle, th)
		sweep();
		$display("test angle done");
		tally_and_finish();
	end
endmodule
